// [eeprom_map.svh]
`ifndef EEPROM_MAP_SVH
`define EEPROM_MAP_SVH
`define CODE_ARRAY 4'hA
`define CODE_SECURE 4'hB
`define PROT_ADDR 16'h0401
`define PROT_HI_BIT 3
`define PROT_LO_BIT 2
`define PAGE_BYTES 32
`define WORD_BYTES 4
`define ADDR_BITS 13
`define WORD_WRITE_NS 40000
`define CLK_NS 25
`define WORD_WRITE_CYC ((`WORD_WRITE_NS + `CLK_NS - 1) / `CLK_NS)
`define LIMIT_1_4 13'h1800
`define LIMIT_1_2 13'h1000
`define CTRL_ADDR 32'h0000_0000
`define DATA_ADDR 32'h0000_0004
`define STAT_ADDR 32'h0000_0008
`define HALF_DIV 8'h04
`endif

// [eeprom_pkg.sv]
package eeprom_pkg;
    typedef enum {
        S_IDLE, S_CTRL, S_ADRH, S_ADRL, S_DATA, S_IGNORE
    } slave_state_t;
    typedef enum {
        M_IDLE, M_START, M_BIT, M_ACK, M_STOP, M_DONE
    } master_state_t;
endpackage

// [two_wire_if.sv]
`timescale 1ns/100ps
interface two_wire_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    wire scl = scl_oe ? scl_o : 1'b1;
    wire sda = (sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o) ? 1'b0
                                                                : 1'b1;
    modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
    modport ctl (input scl, input sda, output scl_o, output scl_oe,
                 output sda_m_o, output sda_m_oe);
endinterface

// [line_sync.sv]
`timescale 1ns/100ps
module line_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pins
    input wire logic scl_i,
    input wire logic sda_i,
    // synchronised view
    output logic scl_o,
    output logic sda_o,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o
);
    logic [1:0] scl_s_r;
    logic [1:0] sda_s_r;
    logic scl_d_r;
    logic sda_d_r;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_s_r <= {scl_s_r[0], scl_i};
            sda_s_r <= {sda_s_r[0], sda_i};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end
    assign scl_o = scl_s_r[1];
    assign sda_o = sda_s_r[1];
    assign scl_rise_o = scl_s_r[1] && !scl_d_r;
    assign scl_fall_o = !scl_s_r[1] && scl_d_r;
    assign start_o = scl_s_r[1] && scl_d_r && sda_d_r && !sda_s_r[1];
    assign stop_o = scl_s_r[1] && scl_d_r && !sda_d_r && sda_s_r[1];
endmodule

// [eeprom_slave.sv]
`timescale 1ns/100ps
`include "eeprom_map.svh"
// Overview of operation
// - code 1010 selects the main array
// - code 1011 selects security and protect space
// - chip-select bits must match internal setting
// - low control bit: one read, zero write; a read control byte is not acknowledged here
// - acknowledge matched control byte on ninth pulse
// - master sends address high then low
// - every byte acknowledged; missing ack restarts
// - load sixteen-bit pointer after low byte
// - stop launches write; no stop discards
// - no acknowledge during internal write cycle
// - address wraps inside 32-byte page
// - single byte costs a full word time
// - page write sends up to 32 bytes
// - over 32 bytes overwrite earliest buffer entries
// - first byte at start, then consecutive
// - page time is word time times words
// - protect register at 1011 address 0401h
// - only bits 3 and 2 kept
// - protect bits select guarded top region
// - protect update committed only on stop
// - master clears protect bits before first use
// - poll with the control byte of write
// - eight bits msb first plus ack
module eeprom_slave #(
    parameter logic [2:0] SELECT = 3'h0,
    parameter int WORD_CYC = `WORD_WRITE_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus
    two_wire_if.dev bus,
    // status
    output logic busy_o,
    output logic [7:0] protect_o
);
    localparam int PB = `PAGE_BYTES;
    logic sda, rise, fall, start, stop;
    line_sync u_sync (
        .clk_i(clk_i), .rst_i(rst_i), .scl_i(bus.scl), .sda_i(bus.sda),
        .scl_o(), .sda_o(sda), .scl_rise_o(rise), .scl_fall_o(fall),
        .start_o(start), .stop_o(stop)
    );
    logic [7:0] mem_r [0:(1 << `ADDR_BITS) - 1];
    logic [7:0] buf_r [0:PB - 1];
    eeprom_pkg::slave_state_t state_r;
    logic [3:0] bit_r;
    logic [7:0] sh_r;
    logic ack_r;
    logic secure_r;
    logic [15:0] addr_r;
    logic [7:0] ahi_r;
    logic [5:0] cnt_r;
    logic [4:0] widx_r;
    logic [1:0] prot_r;
    logic commit_r;
    logic [31:0] timer_r;
    logic [5:0] wr_left_r;
    logic [15:0] wr_addr_r;
    logic [4:0] rd_idx_r;
    logic prot_pend_r;

    function automatic logic guarded(input logic [15:0] a,
                                     input logic [1:0] p);
        case (p)
            2'h1: guarded = a[12:0] >= `LIMIT_1_4;
            2'h2: guarded = a[12:0] >= `LIMIT_1_2;
            2'h3: guarded = 1'b1;
            default: guarded = 1'b0;
        endcase
    endfunction

    function automatic logic [15:0] page_next(input logic [15:0] a);
        page_next = {a[15:5], 5'(a[4:0] + 5'h1)};
    endfunction

    wire byte_done = rise && bit_r == 4'h7;
    wire [7:0] rx = {sh_r[6:0], sda};
    wire ack_slot = bit_r == 4'h8;

    // bit counter and shifter, msb first
    // a start parks the count one below zero, so the scl fall that
    // follows the start is not taken for the end of a data bit
    always_ff @(posedge clk_i) begin
        if (rst_i || start || stop) begin
            bit_r <= 4'hF;
            sh_r <= 8'h00;
        end else if (rise && bit_r < 4'h8) begin
            sh_r <= rx;
        end else if (fall && bit_r == 4'h8) begin
            bit_r <= 4'h0;
        end else if (fall) begin
            bit_r <= bit_r + 4'h1;
        end
    end

    // decode and collect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= eeprom_pkg::S_IDLE;
            ack_r <= 1'b0;
            secure_r <= 1'b0;
            addr_r <= 16'h0000;
            ahi_r <= 8'h00;
            cnt_r <= 6'h00;
            widx_r <= 5'h00;
            commit_r <= 1'b0;
        end else begin
            commit_r <= 1'b0;
            if (start) begin
                state_r <= eeprom_pkg::S_CTRL;
                cnt_r <= 6'h00;
                widx_r <= 5'h00;
            end else if (stop) begin
                // only a stop after data commits
                commit_r <= state_r == eeprom_pkg::S_DATA
                            && cnt_r != 6'h00 && !busy_o;
                state_r <= eeprom_pkg::S_IDLE;
            end else if (byte_done) begin
                ack_r <= 1'b0;
                case (state_r)
                    eeprom_pkg::S_CTRL: begin
                        if ((rx[7:4] == `CODE_ARRAY
                             || rx[7:4] == `CODE_SECURE)
                            && rx[3:1] == SELECT && !rx[0] && !busy_o) begin
                            ack_r <= 1'b1;
                            secure_r <= rx[7:4] == `CODE_SECURE;
                            state_r <= eeprom_pkg::S_ADRH;
                        end else begin
                            state_r <= eeprom_pkg::S_IGNORE;
                        end
                    end
                    eeprom_pkg::S_ADRH: begin
                        ahi_r <= rx;
                        ack_r <= 1'b1;
                        state_r <= eeprom_pkg::S_ADRL;
                    end
                    eeprom_pkg::S_ADRL: begin
                        addr_r <= {ahi_r, rx};
                        ack_r <= 1'b1;
                        state_r <= eeprom_pkg::S_DATA;
                    end
                    eeprom_pkg::S_DATA: begin
                        ack_r <= 1'b1;
                        widx_r <= widx_r + 5'h1;  // wraps over
                        if (cnt_r != 6'(PB)) begin
                            cnt_r <= cnt_r + 6'h1;
                        end
                    end
                    default: state_r <= eeprom_pkg::S_IGNORE;
                endcase
            end else if (fall && ack_slot) begin
                ack_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (byte_done && state_r == eeprom_pkg::S_DATA) begin
            buf_r[widx_r] <= rx;
        end
    end

    // ack drive is changed only after the falling edge of scl
    logic drive_r;
    always_ff @(posedge clk_i) begin
        if (rst_i || start || stop) begin
            drive_r <= 1'b0;
        end else if (fall) begin
            drive_r <= ack_r && bit_r == 4'h7;
        end
    end
    assign bus.sda_s_o = 1'b0;
    assign bus.sda_s_oe = drive_r;

    // internal write cycle: one word time per word spanned from the start offset, unwrapped
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            timer_r <= 32'h0;
            wr_left_r <= 6'h00;
            wr_addr_r <= 16'h0000;
            rd_idx_r <= 5'h00;
            prot_pend_r <= 1'b0;
        end else if (commit_r) begin
            busy_o <= 1'b1;
            wr_addr_r <= addr_r;
            rd_idx_r <= (cnt_r == 6'(PB)) ? widx_r : 5'h00;
            wr_left_r <= cnt_r;
            prot_pend_r <= secure_r && addr_r == `PROT_ADDR;
            // words spanned, rounded to whole words
            timer_r <= WORD_CYC * ((32'(addr_r[1:0]) + 32'(cnt_r)
                       + `WORD_BYTES - 1) / `WORD_BYTES);
        end else if (busy_o) begin
            if (wr_left_r != 6'h00) begin
                wr_left_r <= wr_left_r - 6'h1;
                wr_addr_r <= page_next(wr_addr_r);
                rd_idx_r <= rd_idx_r + 5'h1;
                prot_pend_r <= 1'b0;
            end
            if (timer_r > 32'h1) begin
                timer_r <= timer_r - 32'h1;
            end else begin
                busy_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (busy_o && wr_left_r != 6'h00 && !secure_r
            && !guarded(wr_addr_r, prot_r)) begin
            mem_r[wr_addr_r[`ADDR_BITS-1:0]] <= buf_r[rd_idx_r];
        end
    end

    // protect bits; other secure addresses are outside this block
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prot_r <= 2'h0;
        end else if (busy_o && prot_pend_r) begin
            prot_r <= {buf_r[rd_idx_r][`PROT_HI_BIT],
                       buf_r[rd_idx_r][`PROT_LO_BIT]};
        end
    end
    assign protect_o = {4'h0, prot_r, 2'h0};
endmodule

// [eeprom_ctl.sv]
`timescale 1ns/100ps
`include "eeprom_map.svh"
// bus controller: software loads a byte, kicks with ctrl bits
// ctrl: [0] start-before, [1] stop-after, [2] go; data: byte to send
// stat: [0] busy, [1] last byte acknowledged
module eeprom_ctl #(
    parameter logic [7:0] HALF = `HALF_DIV
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // bus
    two_wire_if.ctl bus
);
    eeprom_pkg::master_state_t st_r;
    logic [7:0] div_r;
    logic [1:0] ph_r;
    logic [7:0] tx_r;
    logic [3:0] n_r;
    logic stop_r, acked_r;
    logic scl_r, sda_r;
    logic [1:0] sda_s_r;
    wire go = cyc_i && stb_i && we_i && !ack_o && adr_i == `CTRL_ADDR
              && sel_i[0] && dat_i[2] && st_r == eeprom_pkg::M_IDLE;
    wire tick = div_r == 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) ack_o <= 1'b0;
        else ack_o <= cyc_i && stb_i && !ack_o;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) dat_o <= 32'h0;
        else if (adr_i == `STAT_ADDR)
            dat_o <= {30'h0, acked_r, st_r != eeprom_pkg::M_IDLE};
        else if (adr_i == `DATA_ADDR) dat_o <= {24'h0, tx_r};
        else dat_o <= 32'h0;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) sda_s_r <= 2'h3;
        else sda_s_r <= {sda_s_r[0], bus.sda};
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || st_r == eeprom_pkg::M_IDLE || tick) div_r <= HALF;
        else div_r <= div_r - 8'h01;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= eeprom_pkg::M_IDLE;
            ph_r <= 2'h0;
            tx_r <= 8'h00;
            n_r <= 4'h0;
            stop_r <= 1'b0;
            acked_r <= 1'b0;
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else if (st_r == eeprom_pkg::M_IDLE) begin
            if (cyc_i && stb_i && we_i && !ack_o && adr_i == `DATA_ADDR
                && sel_i[0]) tx_r <= dat_i[7:0];
            if (go) begin
                stop_r <= dat_i[1];
                ph_r <= 2'h0;
                n_r <= 4'h0;
                st_r <= dat_i[0] ? eeprom_pkg::M_START : eeprom_pkg::M_BIT;
            end
        end else if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (st_r)
                eeprom_pkg::M_START: begin
                    // release both, then pull sda low while scl high
                    case (ph_r)
                        2'h0: sda_r <= 1'b1;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_r <= 1'b0;
                        default: begin
                            scl_r <= 1'b0;
                            st_r <= eeprom_pkg::M_BIT;
                        end
                    endcase
                end
                eeprom_pkg::M_BIT, eeprom_pkg::M_ACK: begin
                    case (ph_r)
                        2'h0: sda_r <= st_r == eeprom_pkg::M_ACK ? 1'b1
                                       : tx_r[3'(4'h7 - n_r)];
                        2'h1: scl_r <= 1'b1;
                        2'h2: if (st_r == eeprom_pkg::M_ACK)
                                  acked_r <= !sda_s_r[1];
                        default: begin
                            scl_r <= 1'b0;
                            n_r <= n_r + 4'h1;
                            if (st_r == eeprom_pkg::M_ACK)
                                st_r <= stop_r ? eeprom_pkg::M_STOP
                                               : eeprom_pkg::M_DONE;
                            else if (n_r == 4'h7)
                                st_r <= eeprom_pkg::M_ACK;
                        end
                    endcase
                end
                eeprom_pkg::M_STOP: begin
                    case (ph_r)
                        2'h0: sda_r <= 1'b0;
                        2'h1: scl_r <= 1'b1;
                        2'h2: sda_r <= 1'b1;
                        default: st_r <= eeprom_pkg::M_DONE;
                    endcase
                end
                default: st_r <= eeprom_pkg::M_IDLE;
            endcase
        end
    end
    assign bus.scl_o = 1'b0;
    assign bus.scl_oe = !scl_r;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = !sda_r;
endmodule

// [eeprom_chk.sv]
`timescale 1ns/100ps
module eeprom_chk #(
    parameter int WC = 400
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // two-wire lines
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    // device status
    input wire logic busy_o,
    input wire logic [7:0] protect_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic scl_q;
    logic sda_q;
    logic busy_q;
    logic [7:0] since_stop;
    logic [15:0] busy_cnt;
    logic [3:0] nbit;
    // stop is seen one sample late, so commits get a short grace window
    always_ff @(posedge clk_i) begin
        scl_q <= scl;
        sda_q <= sda;
        busy_q <= busy_o;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || (scl && scl_q && sda && !sda_q)) since_stop <= 8'h00;
        else if (since_stop != 8'hFF) since_stop <= since_stop + 8'h01;
    end
    // rises since the last start, modulo nine: index 8 is the ack slot
    always_ff @(posedge clk_i) begin
        if (rst_i || (scl && scl_q && !sda && sda_q)) nbit <= 4'h0;
        else if (scl && !scl_q) nbit <= (nbit == 4'h8) ? 4'h0 : nbit + 4'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) busy_cnt <= 16'h0000;
        else if (busy_o) busy_cnt <= busy_q ? busy_cnt + 16'h0001 : 16'h0001;
    end
    reserved_zero_a: assert property (protect_o[7:4] == 4'h0 &&
        protect_o[1:0] == 2'h0) else $error("protect reserved bits set");
    protect_on_stop_a: assert property ($changed(protect_o) |->
        since_stop < 8'h10) else $error("protect changed without stop");
    busy_on_stop_a: assert property ($rose(busy_o) |->
        since_stop < 8'h10) else $error("write cycle without stop");
    no_ack_busy_a: assert property (busy_o |->
        !(sda_s_oe && !sda_s_o)) else $error("ack given while busy");
    ack_ninth_a: assert property ($rose(scl) && sda_s_oe |->
        nbit == 4'h8) else $error("device drives outside ack slot");
    ack_scl_low_a: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("device data moved while clock high");
    ack_held_a: assert property ($rose(scl) && sda_s_oe |->
        sda_s_oe [*3]) else $error("ack released during clock high");
    busy_words_a: assert property ($fell(busy_o) |->
        busy_cnt % WC == 0 && busy_cnt != 16'h0000)
        else $error("write time not whole words");
endmodule

// [tb_i2c_eeprom_write_protect_slave.sv]
`timescale 1ns/100ps
`include "eeprom_map.svh"
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    miscompares++; $display("Error %s expected %0h seen %0h", n, e, g); \
    end end
module tb_i2c_eeprom_write_protect_slave;
    localparam int WC = 400;
    typedef struct {string n; logic [15:0] v;} note_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [31:0] adr_i = 32'h0;
    logic [3:0] sel_i = 4'h0;
    logic [7:0] bad [4] = '{8'hAE, 8'hA1, 8'hC0, 8'h5E};
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o;
    logic busy_o;
    logic [7:0] protect_o;
    logic busy_q = 1'b0;
    logic [15:0] bcnt = 16'h0;
    logic res_vld = 1'b0;
    logic [15:0] res_v = 16'h0;
    note_t nq[$];
    note_t c;
    int miscompares = 0;
    int checks_done = 0;
    logic [7:0] d;
    two_wire_if bus_if();
    eeprom_slave #(.SELECT(3'h0), .WORD_CYC(WC)) i_eeprom_slave (
        .clk_i(clk_i), .rst_i(rst_i), .bus(bus_if),
        .busy_o(busy_o), .protect_o(protect_o));
    eeprom_ctl #(.HALF(8'h04)) i_eeprom_ctl (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .bus(bus_if));
    eeprom_chk #(.WC(WC)) i_eeprom_chk (
        .clk_i(clk_i), .rst_i(rst_i), .scl(bus_if.scl), .sda(bus_if.sda),
        .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
        .busy_o(busy_o), .protect_o(protect_o));
    always #12.5 clk_i = ~clk_i;
    // length of the last write cycle, kept once busy falls
    always @(posedge clk_i) begin
        busy_q <= busy_o;
        if (busy_o) bcnt <= busy_q ? bcnt + 16'h1 : 16'h1;
    end
    always @(posedge clk_i) begin
        if (res_vld === 1'b1) begin
            c = nq.pop_front();
            `CHK(c.n, c.v, res_v)
        end
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic note(input string n, input logic [15:0] e,
                        input logic [15:0] s);
        nq.push_back('{n, e});
        res_v <= s;
        res_vld <= 1'b1;
        @(posedge clk_i);
        res_vld <= 1'b0;
    endtask
    task automatic wb(input logic w, input logic [31:0] a,
                      input logic [31:0] dd, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= dd;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // f: bit0 start before, bit1 stop after
    task automatic xfer(input logic [7:0] b, input logic [1:0] f,
                        input logic a);
        logic [31:0] q;
        wb(1'b1, `DATA_ADDR, {24'h0, b}, q);
        wb(1'b1, `CTRL_ADDR, {29'h0, 1'b1, f}, q);
        do wb(1'b0, `STAT_ADDR, 32'h0, q); while (q[0] !== 1'b0);
        note("ack", {15'h0, a}, {15'h0, q[1]});
    endtask
    task automatic wait_idle;
        while (busy_o !== 1'b0) @(posedge clk_i);
    endtask
    task automatic prot(input logic [7:0] v, input logic p);
        xfer(8'hB0, 2'h1, 1'b1);
        xfer(8'h04, 2'h0, 1'b1);
        xfer(8'h01, 2'h0, 1'b1);
        xfer(v, {p, 1'b0}, 1'b1);
    endtask
    task automatic wr(input logic [15:0] a, input int n);
        xfer(8'hA0, 2'h1, 1'b1);
        xfer(a[15:8], 2'h0, 1'b1);
        xfer(a[7:0], 2'h0, 1'b1);
        for (int k = 0; k < n; k++) begin
            xfer(8'($urandom), {k == n - 1, 1'b0}, 1'b1);
        end
    endtask
    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        end_of_test;
    end
    initial begin
        void'($urandom(66));
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            d = (i == 3) ? 8'h00 : 8'($urandom);
            prot(d, 1'b1);
            wait_idle;
            note("protect", {12'h0, d[3:2], 2'h0},
                 {8'h0, protect_o});
        end
        // protect byte left without stop, then a fresh command
        prot(8'h0C, 1'b0);
        xfer(8'hA0, 2'h3, 1'b1);
        wait_idle;
        note("protect", 16'h0000, {8'h0, protect_o});
        foreach (bad[j]) begin
            xfer(bad[j], 2'h3, 1'b0);
        end
        wr(16'h0010, 1);
        xfer(8'hA0, 2'h3, 1'b0);
        wait_idle;
        note("busy", 16'(WC), bcnt);
        xfer(8'hA0, 2'h3, 1'b1);
        wr(16'h0040, 8);
        wait_idle;
        note("busy", 16'(2 * WC), bcnt);
        wr(16'h005C, 8);
        wait_idle;
        note("busy", 16'(2 * WC), bcnt);
        // one byte past a full buffer: still eight words are written
        wr(16'h0060, 33);
        wait_idle;
        note("busy", 16'(8 * WC), bcnt);
        @(posedge clk_i);
        end_of_test;
    end
endmodule
